/* File: rtl/fpa_params.svh */
`ifndef FPA_PARAMS_SVH
`define FPA_PARAMS_SVH
// Contract
// RULE1 - address-high low byte gives address bits 23:16
// RULE2 - address-low sixteen bits give address bits 15:0
// RULE3 - both address registers read back last write
// RULE4 - address registers power up undefined, no reset
// RULE5 - upper 24 bits of high and key read zero
// RULE6 - key is 8-bit write-only, resets to zero
// RULE7 - key reads zero; each write strobes unlock

`define FPA_AW        12
`define FPA_DW        32
`define FPA_OFS_HI    12'h000
`define FPA_OFS_LO    12'h004
`define FPA_OFS_KEY   12'h008
`define FPA_HI_W      8
`define FPA_LO_W      16
`define FPA_KEY_W     8
`define FPA_TGT_W     24
`define FPA_KEY_RST   8'h00
`define FPA_ZERO32    32'h0000_0000

`endif

/* File: rtl/fpa_pkg.sv */
package fpa_pkg;

    typedef enum logic {
        FPA_PH_IDLE,
        FPA_PH_ANSWER
    } fpa_phase_t;

endpackage : fpa_pkg

/* File: rtl/fpa_bus_if.sv */
`include "fpa_params.svh"

interface fpa_bus_if;
    logic                 wr_en;
    logic [`FPA_AW-1:0]   addr;
    logic [`FPA_DW-1:0]   wdata;
    logic [`FPA_DW-1:0]   rdata;
    logic                 hit;

    modport slave (
        output wr_en,
        output addr,
        output wdata,
        input  rdata,
        input  hit
    );

    modport regs (
        input  wr_en,
        input  addr,
        input  wdata,
        output rdata,
        output hit
    );
endinterface : fpa_bus_if

/* File: rtl/fpa_apb_slave.sv */
`include "fpa_params.svh"

module fpa_apb_slave
    import fpa_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic [`FPA_AW-1:0]   paddr,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [`FPA_DW-1:0]   pwdata,
    output logic      [`FPA_DW-1:0]   prdata,
    output logic                      pready,
    output logic                      pslverr,
    fpa_bus_if.slave                  bus
);

    fpa_phase_t           phase_q,   phase_d;
    logic [`FPA_DW-1:0]   prdata_q,  prdata_d;
    logic                 pready_q,  pready_d;
    logic                 pslverr_q, pslverr_d;
    logic                 access;

    // one wait state so read data can come from a flop
    assign access    = psel && penable;
    assign bus.addr  = paddr;
    assign bus.wdata = pwdata;
    assign bus.wr_en = access && pwrite && bus.hit
                       && (phase_q == FPA_PH_ANSWER);

    always_comb begin
        phase_d   = phase_q;
        prdata_d  = `FPA_ZERO32;
        pready_d  = 1'b0;
        pslverr_d = 1'b0;
        unique case (phase_q)
            FPA_PH_IDLE: begin
                if (access) begin
                    phase_d   = FPA_PH_ANSWER;
                    pready_d  = 1'b1;
                    pslverr_d = !bus.hit;
                    if (!pwrite && bus.hit) begin
                        prdata_d = bus.rdata;
                    end
                end
            end
            FPA_PH_ANSWER: begin
                phase_d = FPA_PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q   <= FPA_PH_IDLE;
            prdata_q  <= `FPA_ZERO32;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            phase_q   <= phase_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

endmodule : fpa_apb_slave

/* File: rtl/fpa_top.sv */
// The APB slave port and the placing of the registers were decided locally.
`include "fpa_params.svh"

module fpa_top
    import fpa_pkg::*;
(
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic [`FPA_AW-1:0]     paddr,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`FPA_DW-1:0]     pwdata,
    output logic      [`FPA_DW-1:0]     prdata,
    output logic                        pready,
    output logic                        pslverr,
    output logic      [`FPA_TGT_W-1:0]  flash_target_address,
    output logic      [`FPA_KEY_W-1:0]  flash_unlock_key,
    output logic                        key_wr_strobe
);

    fpa_bus_if bus ();

    fpa_apb_slave u_slave (
        .pclk    (pclk),
        .presetn (presetn),
        .paddr   (paddr),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .bus     (bus)
    );

    logic [`FPA_HI_W-1:0]   addr_hi_q,  addr_hi_d;
    logic [`FPA_LO_W-1:0]   addr_lo_q,  addr_lo_d;
    logic [`FPA_KEY_W-1:0]  key_q,      key_d;
    logic                   strobe_q,   strobe_d;
    logic                   sel_hi;
    logic                   sel_lo;
    logic                   sel_key;

    assign sel_hi  = (bus.addr == `FPA_OFS_HI);
    assign sel_lo  = (bus.addr == `FPA_OFS_LO);
    assign sel_key = (bus.addr == `FPA_OFS_KEY);
    assign bus.hit = sel_hi || sel_lo || sel_key;

    // read mux; unimplemented upper bits stay zero
    always_comb begin
        bus.rdata = `FPA_ZERO32;
        if (sel_hi) begin
            bus.rdata[`FPA_HI_W-1:0] = addr_hi_q; // RULE3 RULE5
        end else if (sel_lo) begin
            bus.rdata[`FPA_LO_W-1:0] = addr_lo_q; // RULE3
        end
        // key reads fall through as zero so the key cannot leak
    end // RULE7

    always_comb begin
        addr_hi_d = addr_hi_q;
        addr_lo_d = addr_lo_q;
        key_d     = key_q;
        strobe_d  = 1'b0;
        if (bus.wr_en && sel_hi) begin
            // upper write bits dropped
            addr_hi_d = bus.wdata[`FPA_HI_W-1:0]; // RULE5
        end
        if (bus.wr_en && sel_lo) begin
            addr_lo_d = bus.wdata[`FPA_LO_W-1:0]; // RULE3
        end
        if (bus.wr_en && sel_key) begin
            key_d    = bus.wdata[`FPA_KEY_W-1:0]; // RULE6
            strobe_d = 1'b1; // RULE7
        end
    end

    // no reset on purpose: software must load the address first
    always_ff @(posedge pclk) begin
        addr_hi_q <= addr_hi_d; // RULE4
        addr_lo_q <= addr_lo_d; // RULE4
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_q    <= `FPA_KEY_RST; // RULE6
            strobe_q <= 1'b0;
        end else begin
            key_q    <= key_d;
            strobe_q <= strobe_d;
        end
    end

    assign flash_target_address = {addr_hi_q, addr_lo_q}; // RULE1 RULE2
    assign flash_unlock_key     = key_q;
    assign key_wr_strobe        = strobe_q;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic wr_hi;
    logic wr_lo;
    logic wr_key;
    logic rd_ok;
    assign wr_hi  = bus.wr_en && sel_hi;
    assign wr_lo  = bus.wr_en && sel_lo;
    assign wr_key = bus.wr_en && sel_key;
    assign rd_ok  = psel && penable && !pwrite && !pready;

    // address flops carry no reset, so hold checks wait for a first load
    logic hi_loaded_q, hi_loaded_d;
    logic lo_loaded_q, lo_loaded_d;

    always_comb begin
        hi_loaded_d = hi_loaded_q || wr_hi;
        lo_loaded_d = lo_loaded_q || wr_lo;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_loaded_q <= 1'b0;
            lo_loaded_q <= 1'b0;
        end else begin
            hi_loaded_q <= hi_loaded_d;
            lo_loaded_q <= lo_loaded_d;
        end
    end

    hi_to_target_a: assert property ( // RULE1
        wr_hi |=> flash_target_address[`FPA_TGT_W-1:`FPA_LO_W]
                  == $past(pwdata[`FPA_HI_W-1:0])
    ) else $error("address high byte not on target bits 23:16");

    lo_to_target_a: assert property ( // RULE2
        wr_lo |=> flash_target_address[`FPA_LO_W-1:0]
                  == $past(pwdata[`FPA_LO_W-1:0])
    ) else $error("address low half not on target bits 15:0");

    hi_readback_a: assert property ( // RULE3
        rd_ok && sel_hi && !wr_hi
        |=> prdata[`FPA_HI_W-1:0]
            == flash_target_address[`FPA_TGT_W-1:`FPA_LO_W]
    ) else $error("address high readback wrong");

    lo_readback_a: assert property ( // RULE3
        rd_ok && sel_lo
        |=> prdata[`FPA_LO_W-1:0] == flash_target_address[`FPA_LO_W-1:0]
    ) else $error("address low readback wrong");

    addr_hold_a: assert property ( // RULE4
        hi_loaded_q && !wr_hi
        |=> $stable(flash_target_address[`FPA_TGT_W-1:`FPA_LO_W])
    ) else $error("address high byte moved without a write");

    addr_lo_hold_a: assert property ( // RULE4
        lo_loaded_q && !wr_lo
        |=> $stable(flash_target_address[`FPA_LO_W-1:0])
    ) else $error("address low half moved without a write");

    upper_zero_a: assert property ( // RULE5
        pready && (sel_hi || sel_key) && !pwrite
        |-> prdata[`FPA_DW-1:`FPA_HI_W] == 24'h00_0000
    ) else $error("reserved upper bits not zero");

    key_reset_a: assert property ( // RULE6
        $rose(presetn) |-> flash_unlock_key == `FPA_KEY_RST
    ) else $error("key not zero after reset");

    key_hidden_a: assert property ( // RULE7
        rd_ok && sel_key |=> prdata == `FPA_ZERO32
    ) else $error("key register read not zero");

    key_strobe_a: assert property ( // RULE7
        wr_key |=> key_wr_strobe
                   && flash_unlock_key == $past(pwdata[`FPA_KEY_W-1:0])
                   ##1 !key_wr_strobe
    ) else $error("key write strobe wrong");

    strobe_cause_a: assert property ( // RULE7
        key_wr_strobe |-> $past(wr_key)
    ) else $error("key strobe without a key write");

    answer_time_a: assert property (
        psel && penable && !pready |=> pready ##1 !pready
    ) else $error("slave answer not one wait state");

    key_hold_a: assert property ( // RULE6
        !wr_key |=> $stable(flash_unlock_key)
    ) else $error("key changed without a key write");

    strobe_pulse_a: assert property ( // RULE7
        key_wr_strobe |=> !key_wr_strobe
    ) else $error("key strobe longer than one cycle");

    lo_keeps_hi_a: assert property ( // RULE1
        hi_loaded_q && wr_lo
        |=> $stable(flash_target_address[`FPA_TGT_W-1:`FPA_LO_W])
    ) else $error("low write disturbed the high byte");

    hi_keeps_lo_a: assert property ( // RULE2
        lo_loaded_q && wr_hi
        |=> $stable(flash_target_address[`FPA_LO_W-1:0])
    ) else $error("high write disturbed the low half");

    err_unmapped_a: assert property (
        psel && penable && !pready && !bus.hit |=> pready && pslverr
    ) else $error("unmapped access not refused");

    err_mapped_a: assert property (
        pready && bus.hit |-> !pslverr
    ) else $error("mapped access flagged as error");

    rdata_idle_a: assert property (
        !pready |-> prdata == `FPA_ZERO32
    ) else $error("read data outside the answer cycle");

    write_once_a: assert property (
        bus.wr_en |=> !bus.wr_en
    ) else $error("one transfer wrote twice");

    reset_quiet_a: assert property (
        $rose(presetn)
        |-> !pready && !key_wr_strobe && prdata == `FPA_ZERO32
    ) else $error("outputs not quiet after reset");

    answer_single_a: assert property (
        pready |=> !pready
    ) else $error("answer longer than one cycle");

    cov_addr_write_c: cover property (wr_hi ##[1:20] wr_lo);
    cov_key_pair_c:   cover property (wr_key ##[1:20] wr_key);
    cov_bad_addr_c:   cover property (pready && pslverr);
    cov_key_read_c:   cover property (rd_ok && sel_key);
    cov_hi_read_c:    cover property (rd_ok && sel_hi);

endmodule : fpa_top

/* File: dv/fpa_top_tb.sv */
`include "fpa_params.svh"

module fpa_top_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic                   pclk;
    logic                   presetn;
    logic [`FPA_AW-1:0]     paddr;
    logic                   psel;
    logic                   penable;
    logic                   pwrite;
    logic [`FPA_DW-1:0]     pwdata;
    logic [`FPA_DW-1:0]     prdata;
    logic                   pready;
    logic                   pslverr;
    logic [`FPA_TGT_W-1:0]  tgt;
    logic [`FPA_KEY_W-1:0]  key;
    logic                   key_wr_strobe;
    logic [`FPA_DW-1:0]     rd;
    logic                   err;
    int                     fail_count;
    int                     checked;

    fpa_top fpa_top_inst (
        .pclk                 (pclk),
        .presetn              (presetn),
        .paddr                (paddr),
        .psel                 (psel),
        .penable              (penable),
        .pwrite               (pwrite),
        .pwdata               (pwdata),
        .prdata               (prdata),
        .pready               (pready),
        .pslverr              (pslverr),
        .flash_target_address (tgt),
        .flash_unlock_key     (key),
        .key_wr_strobe        (key_wr_strobe)
    );

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    // starts on an edge of its own, so a released psel never gets
    // re-raised in the same time step
    task automatic apb(input logic wr, input logic [`FPA_AW-1:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            chk("pready", 32'(pready), 32'h0000_0001);
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    initial begin
        repeat (3000) @(posedge pclk);
        fail_count++;
        wrap_up();
    end

    initial begin
        fail_count = 0;
        checked = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk("key reset", 32'(key), 32'h0000_0000);
        chk("strobe idle", 32'(key_wr_strobe), 32'h0000_0000);
        apb(1'b1, `FPA_OFS_HI, 32'hFFFF_FFA5);
        apb(1'b0, `FPA_OFS_HI, 32'h0000_0000);
        chk("addr high", rd, 32'h0000_00A5);
        apb(1'b1, `FPA_OFS_LO, 32'hFFFF_1234);
        apb(1'b0, `FPA_OFS_LO, 32'h0000_0000);
        chk("addr low", rd, 32'h0000_1234);
        chk("target", 32'(tgt), 32'h00A5_1234);
        apb(1'b1, `FPA_OFS_LO, 32'h0000_BEEF);
        apb(1'b1, `FPA_OFS_HI, 32'h0000_0C3D);
        #1;
        chk("target b", 32'(tgt), 32'h003D_BEEF);
        // key write: strobe and value show right after the write edge
        apb(1'b1, `FPA_OFS_KEY, 32'hFFFF_FF3C);
        #1;
        chk("strobe hi", 32'(key_wr_strobe), 32'h0000_0001);
        chk("key value", 32'(key), 32'h0000_003C);
        @(posedge pclk);
        #1;
        chk("strobe lo", 32'(key_wr_strobe), 32'h0000_0000);
        // two key writes in a row, as an unlock sequence would do
        apb(1'b1, `FPA_OFS_KEY, 32'h0000_0055);
        apb(1'b1, `FPA_OFS_KEY, 32'h0000_00AA);
        #1;
        chk("key second", 32'(key), 32'h0000_00AA);
        chk("strobe 2nd", 32'(key_wr_strobe), 32'h0000_0001);
        apb(1'b0, `FPA_OFS_KEY, 32'h0000_0000);
        chk("key read", rd, 32'h0000_0000);
        chk("key rd err", 32'(err), 32'h0000_0000);
        // unmapped place: refused, nothing disturbed
        apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
        chk("unmap werr", 32'(err), 32'h0000_0001);
        apb(1'b0, 12'h00C, 32'h0000_0000);
        chk("unmap rd", rd, 32'h0000_0000);
        chk("unmap rerr", 32'(err), 32'h0000_0001);
        chk("target c", 32'(tgt), 32'h003D_BEEF);
        // asynchronous reset in mid-run clears the key at once
        @(posedge pclk);
        presetn <= 1'b0;
        #1;
        chk("key rst2", 32'(key), 32'h0000_0000);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, `FPA_OFS_LO, 32'h0000_0001);
        apb(1'b0, `FPA_OFS_LO, 32'h0000_0000);
        chk("low again", rd, 32'h0000_0001);
        wrap_up();
    end
endmodule : fpa_top_tb
